// ===== rtl/sadc_pkg.sv
// Package for the converter control and result block.
// Assumes an 8-bit special-function register port on the same clock.
//
// Function
// - Enable low holds converter in shutdown.
// - Track mode 0 tracks continuously unless converting.
// - Mode 00 tracks three converter clocks after busy write.
// - Mode 01 tracks three clocks after timer 3.
// - Mode 10 tracks only while start pin low.
// - Mode 11 tracks three clocks after timer 2.
// - Start mode field selects the conversion trigger.
// - Busy write starts only in mode 00.
// - Busy reads one only while a timed track or a conversion runs.
// - Busy falling at conversion end raises enabled completion request.
// - Done flag set by hardware, cleared by software.
// - Window flag set on match, software clears.
// - Justify bit selects right or left layout.
// - Right layout sign-extends differential, zero otherwise.
// - Left layout zeroes low-byte bits five to zero.
// - Differential results are two's complement words.
package sadc_pkg;

  // ----------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] SADC_ADDR_CONFIG = 8'h0bc;
  localparam logic [7:0] SADC_ADDR_RES_LO = 8'h0be;
  localparam logic [7:0] SADC_ADDR_RES_HI = 8'h0bf;
  localparam logic [7:0] SADC_ADDR_CONTROL = 8'h0e8;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] SADC_RST_CONFIG  = 8'h60;
  localparam logic [7:0] SADC_RST_CONTROL = 8'h00;
  localparam logic [7:0] SADC_RST_RESULT  = 8'h00;

  // ----------------------------------------------------------------
  // Control register bit positions
  // ----------------------------------------------------------------
  localparam int SADC_CN_ENABLE = 7;
  localparam int SADC_CN_TRACKM = 6;
  localparam int SADC_CN_DONE   = 5;
  localparam int SADC_CN_BUSY   = 4;
  localparam int SADC_CN_STM_HI = 3;
  localparam int SADC_CN_STM_LO = 2;
  localparam int SADC_CN_WINDOW = 1;
  localparam int SADC_CN_LJUST  = 0;

  // ----------------------------------------------------------------
  // Configuration register fields
  // ----------------------------------------------------------------
  localparam int SADC_CF_PERIOD_HI = 7;
  localparam int SADC_CF_PERIOD_LO = 5;
  localparam int SADC_CF_GAIN_HI   = 2;
  localparam int SADC_CF_GAIN_LO   = 0;

  // ----------------------------------------------------------------
  // Timing counts in converter clocks
  // ----------------------------------------------------------------
  localparam logic [3:0] SADC_TRACK_CLKS = 4'h3;
  localparam logic [3:0] SADC_CONV_CLKS  = 4'hb;

  // Start-of-conversion trigger sources
  typedef enum logic [1:0] {
    SADC_STM_SOFT   = 2'b00,
    SADC_STM_TMR3   = 2'b01,
    SADC_STM_PIN    = 2'b10,
    SADC_STM_TMR2   = 2'b11
  } sadc_stm_e;

  // Sequencer phases
  typedef enum logic [1:0] {
    SADC_ST_IDLE  = 2'b00,
    SADC_ST_TRACK = 2'b01,
    SADC_ST_CONV  = 2'b10
  } sadc_state_e;

  // Special-function register access
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sadc_sfr_s;

  // Controls toward the analog core
  typedef struct packed {
    logic       shutdown;
    logic       track;
    logic       convert;
    logic [2:0] clk_period;
    logic [2:0] gain;
  } sadc_core_ctl_s;

endpackage

// ===== rtl/sadc_format.sv
// Result formatter: places a 10-bit word into the two result bytes.
// Assumes a settled converter word and differential flag on input.
`timescale 1ns/1ps

module sadc_format
  import sadc_pkg::*;
(
  // Converter word
  input  wire logic [9:0] word,
  input  wire logic       diff,
  // Layout select
  input  wire logic       ljust,
  // Formatted bytes
  output logic      [7:0] res_hi,
  output logic      [7:0] res_lo
);

  // ----------------------------------------------------------------
  // Byte layout
  // ----------------------------------------------------------------

  // Place word left or right and extend sign
  always_comb begin
    if (ljust) begin
      res_hi = word[9:2];
      res_lo = {word[1:0], 6'h00};
    end else begin
      res_hi = {{6{diff & word[9]}}, word[9:8]};
      res_lo = word[7:0];
    end
  end

endmodule

// ===== rtl/sadc_ctrl.sv
// Converter control, status and result registers.
// Assumes the SFR port, timers and core share core_clk; the
// convert-start pin is asynchronous. Core reports done per word.
`timescale 1ns/1ps

module sadc_ctrl
  import sadc_pkg::*;
(
  // Clock and reset
  input  wire logic                 core_clk,
  input  wire logic                 rstn,
  // Register port
  input  wire sadc_pkg::sadc_sfr_s  sfr,
  output logic               [7:0]  sfr_rdata,
  // Trigger sources
  input  wire logic                 tmr3_ovf,
  input  wire logic                 tmr2_ovf,
  input  wire logic                 external_convert_start,
  // Converter clock enable pulse
  input  wire logic                 sar_clk_en,
  // Analog core result
  input  wire logic                 core_done,
  input  wire logic          [9:0]  core_word,
  input  wire logic                 core_diff,
  // Window comparator verdict for the finished word
  input  wire logic                 window_hit,
  // Analog core controls
  output sadc_pkg::sadc_core_ctl_s  core_ctl,
  // Completion interrupt request and its enable
  input  wire logic                 done_irq_en,
  output logic                      done_irq
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0]  config_r, config_nxt;       // Configuration register
  logic [7:0]  control_r, control_nxt;     // Control register
  logic [7:0]  res_hi_r, res_hi_nxt;       // Result high byte
  logic [7:0]  res_lo_r, res_lo_nxt;       // Result low byte
  sadc_state_e state_r, state_nxt;         // Sequencer phase
  logic [3:0]  cnt_r, cnt_nxt;             // Converter clock counter
  logic        pin_s1_r, pin_s2_r;         // Pin synchroniser
  logic        pin_d_r;                    // Delayed synced pin
  logic        irq_r, irq_nxt;             // Interrupt pulse
  sadc_core_ctl_s ctl_r, ctl_nxt;          // Core controls
  logic [7:0]  rdata_r, rdata_nxt;         // Read data

  // Formatted bytes
  logic [7:0]  fmt_hi, fmt_lo;

  // Control field views
  logic        en, tm, ljust;
  logic [7:0]  ctl_view;                   // Control bits in force now
  sadc_stm_e   stm;
  logic        trig;
  logic        wr_ctl;
  logic        conv_end;

  // ----------------------------------------------------------------
  // Formatter
  // ----------------------------------------------------------------
  sadc_format u_format (
    .word   (core_word),
    .diff   (core_diff),
    .ljust  (ljust),
    .res_hi (fmt_hi),
    .res_lo (fmt_lo)
  );

  // ----------------------------------------------------------------
  // Pin synchroniser
  // ----------------------------------------------------------------

  // Two stages then one for edge detect
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      pin_s1_r <= 1'b1;
      pin_s2_r <= 1'b1;
      pin_d_r  <= 1'b1;
    end else begin
      pin_s1_r <= external_convert_start;
      pin_s2_r <= pin_s1_r;
      pin_d_r  <= pin_s2_r;
    end
  end

  // ----------------------------------------------------------------
  // Trigger selection
  // ----------------------------------------------------------------

  // Field decode and trigger mux
  always_comb begin
    wr_ctl   = sfr.wr && (sfr.addr == SADC_ADDR_CONTROL);
    // A control write applies in its own cycle, so one write that
    // enables and sets busy starts at once, and a disable write
    // drops the core into shutdown without a lagging cycle
    ctl_view = wr_ctl ? sfr.wdata : control_r;
    en       = ctl_view[SADC_CN_ENABLE];
    tm       = ctl_view[SADC_CN_TRACKM];
    // Layout is taken from the stored bit at completion time
    ljust    = control_r[SADC_CN_LJUST];
    // Busy write is judged against the mode written with it
    stm      = sadc_stm_e'(ctl_view[SADC_CN_STM_HI:SADC_CN_STM_LO]);
    case (stm)
      SADC_STM_SOFT: begin
        // Busy write of 1 only in this mode
        trig = wr_ctl && sfr.wdata[SADC_CN_BUSY];
      end
      SADC_STM_TMR3: trig = tmr3_ovf;
      SADC_STM_PIN:  trig = pin_s2_r && !pin_d_r;
      SADC_STM_TMR2: trig = tmr2_ovf;
      default:       trig = 1'b0;
    endcase
    conv_end = (state_r == SADC_ST_CONV) && core_done;
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------

  // Next phase and counter
  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    case (state_r)
      SADC_ST_IDLE: begin
        if (en && trig) begin
          if (tm && stm != SADC_STM_PIN) begin
            // Timed track window first
            state_nxt = SADC_ST_TRACK;
            cnt_nxt   = '0;
          end else begin
            state_nxt = SADC_ST_CONV;
          end
        end
      end
      SADC_ST_TRACK: begin
        if (!en) begin
          state_nxt = SADC_ST_IDLE;
        end else if (sar_clk_en) begin
          if (cnt_r == SADC_TRACK_CLKS - 4'h1) begin
            state_nxt = SADC_ST_CONV;
          end else begin
            cnt_nxt = cnt_r + 4'h1;
          end
        end
      end
      SADC_ST_CONV: begin
        if (!en || core_done) begin
          state_nxt = SADC_ST_IDLE;
        end
      end
      default: state_nxt = SADC_ST_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // Core controls
  // ----------------------------------------------------------------

  // Shutdown, track and convert levels
  always_comb begin
    ctl_nxt            = '0;
    ctl_nxt.shutdown   = !en;
    ctl_nxt.convert    = (state_nxt == SADC_ST_CONV);
    // Taken from the next value so the core sees a new setting
    // one cycle after the write, not two
    ctl_nxt.clk_period = config_nxt[SADC_CF_PERIOD_HI:SADC_CF_PERIOD_LO];
    ctl_nxt.gain       = config_nxt[SADC_CF_GAIN_HI:SADC_CF_GAIN_LO];
    // Period and gain pass unchanged
    if (en && state_nxt != SADC_ST_CONV) begin
      if (!tm) begin
        ctl_nxt.track = 1'b1;
      end else if (stm == SADC_STM_PIN) begin
        ctl_nxt.track = !pin_s2_r;
      end else begin
        ctl_nxt.track = (state_nxt == SADC_ST_TRACK);
      end
    end
  end

  // ----------------------------------------------------------------
  // Registers and flags
  // ----------------------------------------------------------------

  // Register writes, flag sets and result load
  always_comb begin
    config_nxt  = config_r;
    control_nxt = control_r;
    res_hi_nxt  = res_hi_r;
    res_lo_nxt  = res_lo_r;
    irq_nxt     = 1'b0;
    if (sfr.wr) begin
      case (sfr.addr)
        SADC_ADDR_CONFIG: begin
          config_nxt = {sfr.wdata[7:5], 2'b00, sfr.wdata[2:0]};
        end
        SADC_ADDR_RES_LO: res_lo_nxt = sfr.wdata;
        SADC_ADDR_RES_HI: res_hi_nxt = sfr.wdata;
        SADC_ADDR_CONTROL: begin
          // Busy is hardware owned; writing it only triggers
          control_nxt = {sfr.wdata[7:5], control_r[SADC_CN_BUSY],
                         sfr.wdata[3:0]};
        end
        default: ;
      endcase
    end
    // Busy follows the sequencer
    control_nxt[SADC_CN_BUSY] = (state_nxt != SADC_ST_IDLE);
    if (conv_end) begin
      // Results land with busy falling
      res_hi_nxt = fmt_hi;
      res_lo_nxt = fmt_lo;
      // Sets win over a same-cycle clear
      control_nxt[SADC_CN_DONE] = 1'b1;
      if (window_hit) begin
        control_nxt[SADC_CN_WINDOW] = 1'b1;
      end
      irq_nxt = done_irq_en;
    end
  end

  // Read mux
  always_comb begin
    case (sfr.addr)
      SADC_ADDR_CONFIG:  rdata_nxt = config_r;
      SADC_ADDR_RES_LO:  rdata_nxt = res_lo_r;
      SADC_ADDR_RES_HI:  rdata_nxt = res_hi_r;
      SADC_ADDR_CONTROL: rdata_nxt = control_r;
      default:           rdata_nxt = 8'h00;
    endcase
    if (!sfr.rd) begin
      rdata_nxt = rdata_r;
    end
  end

  // Register all state
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      config_r  <= SADC_RST_CONFIG;
      control_r <= SADC_RST_CONTROL;
      res_hi_r  <= SADC_RST_RESULT;
      res_lo_r  <= SADC_RST_RESULT;
      state_r   <= SADC_ST_IDLE;
      cnt_r     <= '0;
      irq_r     <= 1'b0;
      ctl_r     <= '{shutdown: 1'b1, default: '0};
      rdata_r   <= 8'h00;
    end else begin
      config_r  <= config_nxt;
      control_r <= control_nxt;
      res_hi_r  <= res_hi_nxt;
      res_lo_r  <= res_lo_nxt;
      state_r   <= state_nxt;
      cnt_r     <= cnt_nxt;
      irq_r     <= irq_nxt;
      ctl_r     <= ctl_nxt;
      rdata_r   <= rdata_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign sfr_rdata = rdata_r;
  assign core_ctl  = ctl_r;
  assign done_irq  = irq_r;

endmodule

// ===== verification/sadc_core_model.sv
// Behavioural analog core: converter clock, conversion time, result.
// Assumes core_ctl from the control block; words come from the bench.
`timescale 1ns/1ps
module sadc_core_model
  import sadc_pkg::*;
#(
  parameter int CONV_LEN = 12  // Cycles from convert to result
)(
  // Clock and reset
  input  wire logic                     core_clk,
  input  wire logic                     rstn,
  // Controls and bench values
  input  wire sadc_pkg::sadc_core_ctl_s core_ctl,
  input  wire logic              [9:0]  word_in,
  input  wire logic                     diff_in,
  input  wire logic                     hit_in,
  // Toward the control block
  output logic                          sar_clk_en,
  output logic                          core_done,
  output logic                   [9:0]  core_word,
  output logic                          core_diff,
  output logic                          window_hit
);
  logic [1:0] div_r;  // Converter clock divider
  logic [4:0] cnt_r;  // Cycles spent converting
  always_ff @(posedge core_clk) begin
    div_r <= rstn ? div_r + 2'h1 : 2'h0;
    cnt_r <= (rstn && core_ctl.convert) ? cnt_r + 5'h01 : 5'h00;
  end
  assign sar_clk_en = (div_r == 2'h3);
  assign core_done  = core_ctl.convert && (cnt_r == 5'(CONV_LEN));
  // Result lines carry junk outside the done cycle
  assign core_word  = core_done ? word_in : ~word_in;
  assign window_hit = core_done ? hit_in : ~hit_in;
  assign core_diff  = diff_in;
endmodule

// ===== verification/sadc_ctrl_assertions.sv
// Port checks for the converter control block.
// Assumes binding to sadc_ctrl; one clock, sync active-low reset.
`timescale 1ns/1ps
module sadc_ctrl_assertions
  import sadc_pkg::*;
(
  // Clock and reset
  input wire logic                     core_clk,
  input wire logic                     rstn,
  // Watched ports
  input wire sadc_pkg::sadc_sfr_s      sfr,
  input wire logic                     sar_clk_en,
  input wire logic                     core_done,
  input wire sadc_pkg::sadc_core_ctl_s core_ctl,
  input wire logic                     done_irq_en,
  input wire logic                     done_irq
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  logic [3:0] trk_r, trk_nxt;  // Converter clocks seen while tracking
  logic       fix_r, fix_nxt;  // Fixed-length tracking programmed
  logic       cw;              // Control register write
  assign cw = sfr.wr && (sfr.addr == SADC_ADDR_CONTROL);
  // Next values of helper state
  always_comb begin
    trk_nxt = core_ctl.track ? trk_r + {3'h0, sar_clk_en} : 4'h0;
    fix_nxt = cw ? (sfr.wdata[6] && sfr.wdata[3:2] != 2'b10) : fix_r;
  end
  // Helper registers
  always_ff @(posedge core_clk) begin
    trk_r <= rstn ? trk_nxt : 4'h0;
    fix_r <= rstn ? fix_nxt : 1'b0;
  end
  AST_OFF_SHUTDOWN: assert property (cw && !sfr.wdata[7] |=> core_ctl.shutdown)
    else $error("disable did not shut down");
  AST_ON_AWAKE: assert property (cw && sfr.wdata[7] |=> !core_ctl.shutdown)
    else $error("enable did not wake");
  AST_SHUT_IDLE: assert property (core_ctl.shutdown |-> !core_ctl.convert && !core_ctl.track)
    else $error("activity in shutdown");
  AST_NO_TRACK_IN_CONV: assert property (!(core_ctl.track && core_ctl.convert))
    else $error("track during convert");
  AST_TRACK_LEN: assert property (fix_r && $fell(core_ctl.track) && core_ctl.convert |-> trk_r == SADC_TRACK_CLKS)
    else $error("track length wrong");
  AST_CFG_FIELDS: assert property (sfr.wr && sfr.addr == SADC_ADDR_CONFIG |=> core_ctl.clk_period == $past(sfr.wdata[7:5]) && core_ctl.gain == $past(sfr.wdata[2:0]))
    else $error("config fields not driven");
  AST_DONE_ENDS: assert property (core_done && core_ctl.convert |=> !core_ctl.convert)
    else $error("convert outlived done");
  AST_IRQ_MADE: assert property (core_done && core_ctl.convert && done_irq_en |=> done_irq)
    else $error("missing completion request");
  AST_IRQ_CAUSE: assert property (done_irq |-> $past(core_done) && $past(done_irq_en) ##1 !done_irq)
    else $error("stray completion request");
  COV_IRQ: cover property (done_irq);
  COV_FIXED_TRACK: cover property (fix_r && $fell(core_ctl.track));
  COV_CONV: cover property ($rose(core_ctl.convert));
endmodule

bind sadc_ctrl sadc_ctrl_assertions u_chk (
  .core_clk(core_clk), .rstn(rstn), .sfr(sfr), .sar_clk_en(sar_clk_en),
  .core_done(core_done), .core_ctl(core_ctl),
  .done_irq_en(done_irq_en), .done_irq(done_irq)
);

// ===== verification/tb_top.sv
// Self-checking bench for the converter control block.
// Assumes sadc_core_model as the analog core and the bound checker.
`timescale 1ns/1ps
module tb_top;
  import sadc_pkg::*;
  logic           core_clk = 1'b0;
  logic           rstn = 1'b0;
  sadc_sfr_s      sfr = '0;
  logic [7:0]     sfr_rdata;
  logic           tmr3_ovf = 1'b0, tmr2_ovf = 1'b0;
  logic           external_convert_start = 1'b1;
  logic           sar_clk_en, core_done, core_diff, window_hit;
  logic [9:0]     core_word, word_in = 10'h2a5;
  logic           diff_in = 1'b0, hit_in = 1'b1;
  logic           done_irq_en = 1'b1, done_irq;
  sadc_core_ctl_s core_ctl;
  int             errors = 0, samples_checked = 0, cycles = 0;
  int             irq_n = 0, irq0 = 0;
  sadc_ctrl dut (.core_clk(core_clk), .rstn(rstn), .sfr(sfr),
    .sfr_rdata(sfr_rdata), .tmr3_ovf(tmr3_ovf), .tmr2_ovf(tmr2_ovf),
    .external_convert_start(external_convert_start),
    .sar_clk_en(sar_clk_en), .core_done(core_done), .core_word(core_word),
    .core_diff(core_diff), .window_hit(window_hit), .core_ctl(core_ctl),
    .done_irq_en(done_irq_en), .done_irq(done_irq));
  sadc_core_model u_core (.core_clk(core_clk), .rstn(rstn),
    .core_ctl(core_ctl), .word_in(word_in), .diff_in(diff_in),
    .hit_in(hit_in), .sar_clk_en(sar_clk_en), .core_done(core_done),
    .core_word(core_word), .core_diff(core_diff), .window_hit(window_hit));
  always #5 core_clk = ~core_clk;
  // Timeout and completion-request counting
  always @(posedge core_clk) begin
    cycles++;
    if (done_irq === 1'b1) irq_n++;
    if (cycles == 20000) begin
      errors++;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("Checks %0d, mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk) #1;
    sfr = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge core_clk) #1;
    sfr.wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk) #1;
    sfr = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge core_clk) #1;
    sfr.rd = 1'b0;
    @(posedge core_clk) #1;
    d = sfr_rdata;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    chk(d, e);
  endtask
  // Polls the completion flag, not busy
  task automatic wait_done(output logic [7:0] d);
    d = 8'h00;
    for (int i = 0; i < 100 && d[SADC_CN_DONE] !== 1'b1; i++)
      rd(SADC_ADDR_CONTROL, d);
  endtask
  task automatic pulse(input bit t3);
    @(posedge core_clk) #1;
    if (t3) tmr3_ovf = 1'b1;
    else tmr2_ovf = 1'b1;
    @(posedge core_clk) #1;
    tmr3_ovf = 1'b0;
    tmr2_ovf = 1'b0;
  endtask
  task automatic t_reset();
    rdc(SADC_ADDR_CONFIG, SADC_RST_CONFIG);
    rdc(SADC_ADDR_CONTROL, SADC_RST_CONTROL);
    rdc(SADC_ADDR_RES_LO, SADC_RST_RESULT);
    rdc(SADC_ADDR_RES_HI, SADC_RST_RESULT);
    rdc(8'h0bd, 8'h00);
    chk({7'h00, core_ctl.shutdown}, 8'h01);
    wr(SADC_ADDR_CONFIG, 8'ha5);
    rdc(SADC_ADDR_CONFIG, 8'ha5);
    chk({2'h0, core_ctl.clk_period, core_ctl.gain}, 8'h2d);
    $display("reset and config test finished");
  endtask
  // Layouts: diff, justify, expected high, expected low
  task automatic t_layout();
    logic [7:0]  d;
    logic [17:0] tv [3];
    tv = '{{2'b10, 8'hfe, 8'ha5}, {2'b00, 8'h02, 8'ha5},
           {2'b01, 8'ha9, 8'h40}};
    for (int i = 0; i < 3; i++) begin
      diff_in = tv[i][17];
      irq0 = irq_n;
      wr(SADC_ADDR_CONTROL, {7'h48, tv[i][16]});
      wait_done(d);
      chk(d, {7'h51, tv[i][16]});
      chk({7'h00, core_ctl.track}, 8'h01);
      rdc(SADC_ADDR_RES_HI, tv[i][15:8]);
      rdc(SADC_ADDR_RES_LO, tv[i][7:0]);
      chk(8'(irq_n - irq0), 8'h01);
      wr(SADC_ADDR_CONTROL, 8'h80);
      rdc(SADC_ADDR_CONTROL, 8'h80);
    end
    $display("layout test finished");
  endtask
  // Each trigger mode with busy-write and timer decoys from the other sources first
  task automatic t_trig();
    logic [7:0] c, d;
    hit_in = 1'b0;
    for (int m = 0; m < 4; m++) begin
      c = {4'hc, 2'(m), 2'h0};
      irq0 = irq_n;
      wr(SADC_ADDR_CONTROL, c);
      if (m != 0) wr(SADC_ADDR_CONTROL, c | 8'h10);
      if (m != 1) pulse(1'b1);
      if (m != 3) pulse(1'b0);
      rdc(SADC_ADDR_CONTROL, c);
      chk({7'h00, core_ctl.track}, 8'h00);
      case (m)
        0: wr(SADC_ADDR_CONTROL, c | 8'h10);
        1: pulse(1'b1);
        2: begin
          external_convert_start = 1'b0;
          repeat (4) @(posedge core_clk);
          #1;
          chk({7'h00, core_ctl.track}, 8'h01);
          external_convert_start = 1'b1;
        end
        default: pulse(1'b0);
      endcase
      wait_done(d);
      chk(d, c | 8'h20);
      chk(8'(irq_n - irq0), 8'h01);
    end
    $display("trigger test finished");
  endtask
  task automatic t_off();
    logic [7:0] d;
    irq0 = irq_n;
    wr(SADC_ADDR_CONTROL, 8'h04);
    pulse(1'b1);
    rdc(SADC_ADDR_CONTROL, 8'h04);
    chk({7'h00, core_ctl.shutdown}, 8'h01);
    done_irq_en = 1'b0;
    wr(SADC_ADDR_CONTROL, 8'h90);
    wait_done(d);
    chk(d, 8'ha0);
    chk(8'(irq_n - irq0), 8'h00);
    done_irq_en = 1'b1;
    $display("disable test finished");
  endtask
  initial begin
    repeat (3) @(posedge core_clk);
    #1;
    rstn = 1'b1;
    t_reset();
    t_layout();
    t_trig();
    t_off();
    stop_test();
  end
endmodule
